// *** logic/erac_top.sv ***
// Error record address capture and control registers for one node.
// Assumes event and capture strobes come from node logic on CORE_CLK.
// Both access paths are driven by the same clock domain.

// Summary of operation
// - Recording an error with an address stores that address in the record.
// - Space bits encode secure, root, non-secure, realm; else one bit secure/non-secure.
// - With realm support, security-incorrect flags untrusted space bits.
// - Without realm support, security-incorrect flags an untrusted non-secure bit.
// - Address-incorrect at bit 61 flags a possibly invalid captured address.
// - Address, security and virtual flags are fixed as software writable.
// - Address fields clear on cold reset and hold across recovery reset.
// - Virtual flag at bit 60 marks a captured virtual address.
// - Virtual capture forces security 0, incorrect flags 1, space bit 0.
// - Without the virtual flag, a virtual capture still forces those values.
// - Bit 59 is the space bit with realm support; else it and 58:56 zero.
// - Address field is bits 55:0; unimplemented bits read zero.
// - Address writes ignored while status valid, unless injection allows them.
// - Control register exists only for the first record; others read zero.
// - Unsupported control bits read zero and ignore writes.
// - Control bits 63:32 tolerate zero writes; 31:14 and 12 read zero.
// - Critical enable raises critical interrupt; disabled means uncontained.
// - Split deferred mode: bit 11 enables recovery interrupt on write errors.
// - Shared deferred mode: bit 10 enables recovery interrupt for all deferred.
// - Split deferred mode: bit 10 covers deferred errors on reads only.
// - Split corrected mode: bit 9 enables fault interrupt for write events.
// - Corrected event is counter overflow when counters exist, else each one.
// - Interrupts still fire when the syndrome is dropped for priority.
// - Interrupt enables clear on cold reset and hold across recovery reset.
// - Enables not selected by their feature field read zero.
module erac_top
  import erac_pkg::*;
#(
  parameter int         NUM_REC       = 4,
  parameter int         PA_BITS       = 48,
  parameter int         GRAN_LSB      = 0,
  parameter bit         RME_IMPL      = 1'b1,
  parameter bit         VA_IMPL       = 1'b1,
  parameter bit         FI_MODEL_IMPL = 1'b0,
  parameter bit         FI_AV_CAP     = 1'b0,
  parameter logic [1:0] CI_FEAT       = 2'h2,
  parameter logic [1:0] DUI_FEAT      = 2'h3,
  parameter logic [1:0] CFI_FEAT      = 2'h3,
  parameter bit         CE_CNT_IMPL   = 1'b0,
  localparam int        IW            = (NUM_REC > 1) ? $clog2(NUM_REC) : 1,
  localparam int        MAW           = IW + REC_SHIFT
) (
  input  wire logic               CORE_CLK,
  input  wire logic               SRST,
  input  wire logic               ERR_RECOVERY_RST,
  input  wire logic [IW-1:0]      SR_SEL,
  input  wire erac_sreg_t         SR_REG,
  input  wire logic               SR_WR,
  input  wire logic               SR_RD,
  input  wire logic [63:0]        SR_WDATA,
  output logic      [63:0]        SR_RDATA,
  input  wire logic [MAW-1:0]     MM_ADDR,
  input  wire logic               MM_WR,
  input  wire logic               MM_RD,
  input  wire logic [63:0]        MM_WDATA,
  output logic      [63:0]        MM_RDATA,
  input  wire logic               CAP_VALID,
  input  wire logic [IW-1:0]      CAP_REC,
  input  wire logic [55:0]        CAP_ADDR,
  input  wire logic               CAP_NS,
  input  wire logic               CAP_NSE,
  input  wire logic               CAP_SI,
  input  wire logic               CAP_AI,
  input  wire logic               CAP_VA,
  input  wire logic [NUM_REC-1:0] STATUS_AV,
  input  wire logic               EV_CRIT,
  input  wire logic               EV_DEFERRED,
  input  wire logic               EV_CORRECTED,
  input  wire logic               EV_WRITE,
  input  wire logic               CE_OVF_SET,
  output logic                    CRIT_IRQ,
  output logic                    CRIT_AS_UNCONTAINED,
  output logic                    RECOVERY_IRQ,
  output logic                    FAULT_IRQ
);

  // ----------------------------------------------------------------
  // Implemented control bits
  // ----------------------------------------------------------------
  localparam logic [63:0] CTL_MASK =
      ((CI_FEAT == FEAT_ALL)    ? (64'h1 << C_CI_BIT)   : 64'h0)
    | ((DUI_FEAT == FEAT_SPLIT) ? (64'h1 << C_WRITE_DEFERRED_RECOVERY_IRQ_ENABLE_BIT) : 64'h0)
    | ((DUI_FEAT == FEAT_ALL || DUI_FEAT == FEAT_SPLIT)
                                ? (64'h1 << C_DUI_BIT)  : 64'h0)
    | ((CFI_FEAT == FEAT_SPLIT) ? (64'h1 << C_WRITE_CORRECTED_FAULT_IRQ_ENABLE_BIT) : 64'h0)
    | ((CFI_FEAT == FEAT_ALL || CFI_FEAT == FEAT_SPLIT)
                                ? (64'h1 << C_CFI_BIT)  : 64'h0);

  logic [IW-1:0] mm_rec;
  logic [5:0]    mm_off;
  logic          sr_ctl_wr;
  logic          mm_ctl_wr;

  assign mm_rec = MM_ADDR[MAW-1:REC_SHIFT];
  assign mm_off = MM_ADDR[REC_SHIFT-1:0];

  // Only record 0 owns a control register
  assign sr_ctl_wr = SR_WR && SR_REG == ERAC_SREG_CTL && SR_SEL == '0;
  assign mm_ctl_wr = MM_WR && mm_off == CTL_OFF && mm_rec == '0;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [63:0] ctl_r, ctl_nxt;

  always_comb begin
    ctl_nxt = ctl_r;
    if (sr_ctl_wr) begin
      ctl_nxt = SR_WDATA & CTL_MASK;
    end else if (mm_ctl_wr) begin
      ctl_nxt = MM_WDATA & CTL_MASK;
    end
  end

  // Cold reset clears; recovery reset leaves the enables alone
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Address capture records
  // ----------------------------------------------------------------
  logic [63:0] rec_data [NUM_REC];

  for (genvar i = 0; i < NUM_REC; i++) begin : g_rec
    logic sr_hit;
    logic mm_hit;
    assign sr_hit = SR_WR && SR_REG == ERAC_SREG_ADDR && SR_SEL == IW'(i);
    assign mm_hit = MM_WR && mm_off == ADDR_OFF && mm_rec == IW'(i);

    erac_addr_rec #(
      .RME_IMPL      (RME_IMPL),
      .VA_IMPL       (VA_IMPL),
      .PA_BITS       (PA_BITS),
      .GRAN_LSB      (GRAN_LSB),
      .FI_MODEL_IMPL (FI_MODEL_IMPL),
      .FI_AV_CAP     (FI_AV_CAP)
    ) u_rec (
      .clk       (CORE_CLK),
      .srst      (SRST),
      .cap_en    (CAP_VALID && CAP_REC == IW'(i)),
      .cap_addr  (CAP_ADDR),
      .cap_ns    (CAP_NS),
      .cap_nse   (CAP_NSE),
      .cap_si    (CAP_SI),
      .cap_ai    (CAP_AI),
      .cap_va    (CAP_VA),
      .wr_en     (sr_hit || mm_hit),
      .wr_data   (sr_hit ? SR_WDATA : MM_WDATA),
      .status_av (STATUS_AV[i]),
      .rd_data   (rec_data[i])
    );
  end

  // ----------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------
  logic [63:0] sr_rdata_r, sr_rdata_nxt;
  logic [63:0] mm_rdata_r, mm_rdata_nxt;

  always_comb begin
    sr_rdata_nxt = sr_rdata_r;
    mm_rdata_nxt = mm_rdata_r;
    if (SR_RD) begin
      sr_rdata_nxt = '0;
      if (SR_REG == ERAC_SREG_CTL) begin
        if (SR_SEL == '0) begin
          sr_rdata_nxt = ctl_r;
        end
      end else if (int'(SR_SEL) < NUM_REC) begin
        sr_rdata_nxt = rec_data[SR_SEL];
      end
    end
    if (MM_RD) begin
      mm_rdata_nxt = '0;
      if (mm_off == CTL_OFF && mm_rec == '0) begin
        mm_rdata_nxt = ctl_r;
      end else if (mm_off == ADDR_OFF && int'(mm_rec) < NUM_REC) begin
        mm_rdata_nxt = rec_data[mm_rec];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sr_rdata_r <= '0;
      mm_rdata_r <= '0;
    end else begin
      sr_rdata_r <= sr_rdata_nxt;
      mm_rdata_r <= mm_rdata_nxt;
    end
  end

  assign SR_RDATA = sr_rdata_r;
  assign MM_RDATA = mm_rdata_r;

  // ----------------------------------------------------------------
  // Interrupt generation
  // ----------------------------------------------------------------
  logic crit_r, crit_nxt;
  logic unc_r, unc_nxt;
  logic rec_irq_r, rec_irq_nxt;
  logic flt_irq_r, flt_irq_nxt;
  logic ce_event;

  // Overflow of a counter is the event when counters exist
  assign ce_event = CE_CNT_IMPL ? CE_OVF_SET : EV_CORRECTED;

  // Events are not gated by whether the syndrome was kept
  always_comb begin
    crit_nxt = EV_CRIT && ctl_r[C_CI_BIT];
    unc_nxt  = EV_CRIT && !ctl_r[C_CI_BIT];
    if (DUI_FEAT == FEAT_SPLIT) begin
      rec_irq_nxt = EV_DEFERRED && (EV_WRITE ? ctl_r[C_WRITE_DEFERRED_RECOVERY_IRQ_ENABLE_BIT]
                                             : ctl_r[C_DUI_BIT]);
    end else begin
      rec_irq_nxt = EV_DEFERRED && ctl_r[C_DUI_BIT];
    end
    if (CFI_FEAT == FEAT_SPLIT) begin
      flt_irq_nxt = ce_event && (EV_WRITE ? ctl_r[C_WRITE_CORRECTED_FAULT_IRQ_ENABLE_BIT]
                                          : ctl_r[C_CFI_BIT]);
    end else begin
      flt_irq_nxt = ce_event && ctl_r[C_CFI_BIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      crit_r    <= 1'b0;
      unc_r     <= 1'b0;
      rec_irq_r <= 1'b0;
      flt_irq_r <= 1'b0;
    end else begin
      crit_r    <= crit_nxt;
      unc_r     <= unc_nxt;
      rec_irq_r <= rec_irq_nxt;
      flt_irq_r <= flt_irq_nxt;
    end
  end

  assign CRIT_IRQ            = crit_r;
  assign CRIT_AS_UNCONTAINED = unc_r;
  assign RECOVERY_IRQ        = rec_irq_r;
  assign FAULT_IRQ           = flt_irq_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ctl_other_zero;
    @(posedge CORE_CLK) disable iff (SRST)
    SR_RD && SR_REG == ERAC_SREG_CTL && SR_SEL != '0 |=> SR_RDATA == '0;
  endproperty
  a_ctl_other_zero: assert property (p_ctl_other_zero)
    else $error("Control read of other record not zero");

  property p_ctl_mask;
    @(posedge CORE_CLK) disable iff (SRST)
    (ctl_r & ~CTL_MASK) == '0;
  endproperty
  a_ctl_mask: assert property (p_ctl_mask)
    else $error("Unsupported control bit set");

  property p_crit_irq;
    @(posedge CORE_CLK) disable iff (SRST)
    EV_CRIT |=> (CRIT_IRQ != CRIT_AS_UNCONTAINED) && CRIT_IRQ == $past(ctl_r[C_CI_BIT]);
  endproperty
  a_crit_irq: assert property (p_crit_irq)
    else $error("Critical event routed wrongly");

  property p_wr_deferred;
    @(posedge CORE_CLK) disable iff (SRST)
    DUI_FEAT == FEAT_SPLIT && EV_DEFERRED && EV_WRITE && ctl_r[C_WRITE_DEFERRED_RECOVERY_IRQ_ENABLE_BIT]
      |=> RECOVERY_IRQ;
  endproperty
  a_wr_deferred: assert property (p_wr_deferred)
    else $error("Write deferred interrupt missing");

  property p_rd_deferred_only;
    @(posedge CORE_CLK) disable iff (SRST)
    DUI_FEAT == FEAT_SPLIT && EV_DEFERRED && !EV_WRITE |=>
      RECOVERY_IRQ == $past(ctl_r[C_DUI_BIT]);
  endproperty
  a_rd_deferred_only: assert property (p_rd_deferred_only)
    else $error("Read deferred interrupt mismatch");

  property p_wr_corrected;
    @(posedge CORE_CLK) disable iff (SRST)
    CFI_FEAT == FEAT_SPLIT && ce_event && EV_WRITE |=>
      FAULT_IRQ == $past(ctl_r[C_WRITE_CORRECTED_FAULT_IRQ_ENABLE_BIT]);
  endproperty
  a_wr_corrected: assert property (p_wr_corrected)
    else $error("Write corrected interrupt mismatch");

  property p_no_event_no_irq;
    @(posedge CORE_CLK) disable iff (SRST)
    !EV_DEFERRED && !ce_event ##1 1'b1 |-> !RECOVERY_IRQ && !FAULT_IRQ;
  endproperty
  a_no_event_no_irq: assert property (p_no_event_no_irq)
    else $error("Interrupt without event");

  property p_recovery_hold;
    @(posedge CORE_CLK) disable iff (SRST)
    ERR_RECOVERY_RST && !sr_ctl_wr && !mm_ctl_wr |=> $stable(ctl_r);
  endproperty
  a_recovery_hold: assert property (p_recovery_hold)
    else $error("Control changed over recovery reset");

  property p_shared_view;
    @(posedge CORE_CLK) disable iff (SRST)
    mm_ctl_wr && !sr_ctl_wr ##1 SR_RD && SR_REG == ERAC_SREG_CTL && SR_SEL == '0
      |=> SR_RDATA == ($past(MM_WDATA, 2) & CTL_MASK);
  endproperty
  a_shared_view: assert property (p_shared_view)
    else $error("Paths do not share control storage");

endmodule

// *** logic/erac_pkg.sv ***
// Constants for the error record address capture and control block.
// Assumes a single clock domain and a 64-bit register view per record.
package erac_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [5:0] CTL_OFF     = 6'h08;
  localparam logic [5:0] ADDR_OFF    = 6'h18;
  localparam int         REC_SHIFT   = 6;

  // ----------------------------------------------------------------
  // Address capture fields
  // ----------------------------------------------------------------
  localparam int         A_NS_BIT    = 63;
  localparam int         A_SI_BIT    = 62;
  localparam int         A_AI_BIT    = 61;
  localparam int         A_VA_BIT    = 60;
  localparam int         A_NSE_BIT   = 59;
  localparam int         A_PA_MSB    = 55;
  localparam int         A_PA_W      = 56;

  // ----------------------------------------------------------------
  // Control fields and feature encodings
  // ----------------------------------------------------------------
  localparam int         C_CI_BIT    = 13;
  localparam int         C_WRITE_DEFERRED_RECOVERY_IRQ_ENABLE_BIT  = 11;
  localparam int         C_DUI_BIT   = 10;
  localparam int         C_WRITE_CORRECTED_FAULT_IRQ_ENABLE_BIT  = 9;
  localparam int         C_CFI_BIT   = 8;
  localparam logic [1:0] FEAT_ALL    = 2'h2;
  localparam logic [1:0] FEAT_SPLIT  = 2'h3;

  typedef enum logic {ERAC_SREG_CTL, ERAC_SREG_ADDR} erac_sreg_t;

endpackage

// *** logic/erac_addr_rec.sv ***
// One address capture record: stored fields, capture and software write.
// Assumes capture and write strobes come from logic on the same clock.
module erac_addr_rec
  import erac_pkg::*;
#(
  parameter bit RME_IMPL      = 1'b1,
  parameter bit VA_IMPL       = 1'b1,
  parameter int PA_BITS       = 48,
  parameter int GRAN_LSB      = 0,
  parameter bit FI_MODEL_IMPL = 1'b0,
  parameter bit FI_AV_CAP     = 1'b0
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          cap_en,
  input  wire logic [55:0]   cap_addr,
  input  wire logic          cap_ns,
  input  wire logic          cap_nse,
  input  wire logic          cap_si,
  input  wire logic          cap_ai,
  input  wire logic          cap_va,
  input  wire logic          wr_en,
  input  wire logic [63:0]   wr_data,
  input  wire logic          status_av,
  output logic      [63:0]   rd_data
);

  // ----------------------------------------------------------------
  // Field storage
  // ----------------------------------------------------------------
  localparam logic [55:0] PA_MASK =
    ((56'h1 << PA_BITS) - 56'h1) & ~((56'h1 << GRAN_LSB) - 56'h1);

  logic        nonsecure_attr_r, nonsecure_attr_nxt;
  logic        space_extension_bit_r, space_extension_bit_nxt;
  logic        sec_incorrect_r, sec_incorrect_nxt;
  logic        address_incorrect_r, address_incorrect_nxt;
  logic        virtual_address_flag_r, virtual_address_flag_nxt;
  logic [55:0] paddr_r, paddr_nxt;
  logic        wr_lock;

  assign wr_lock = status_av && (!FI_MODEL_IMPL || !FI_AV_CAP);

  always_comb begin
    nonsecure_attr_nxt       = nonsecure_attr_r;
    space_extension_bit_nxt  = space_extension_bit_r;
    sec_incorrect_nxt        = sec_incorrect_r;
    address_incorrect_nxt    = address_incorrect_r;
    virtual_address_flag_nxt = virtual_address_flag_r;
    paddr_nxt                = paddr_r;
    if (cap_en) begin
      paddr_nxt = cap_addr & PA_MASK;
      if (cap_va) begin
        nonsecure_attr_nxt       = 1'b0;
        sec_incorrect_nxt        = 1'b1;
        address_incorrect_nxt    = 1'b1;
        space_extension_bit_nxt  = 1'b0;
        virtual_address_flag_nxt = VA_IMPL;
      end else begin
        nonsecure_attr_nxt       = cap_ns;
        sec_incorrect_nxt        = cap_si;
        address_incorrect_nxt    = cap_ai;
        space_extension_bit_nxt  = RME_IMPL && cap_nse;
        virtual_address_flag_nxt = 1'b0;
      end
    end else if (wr_en && !wr_lock) begin
      // Flags are read/write by software
      nonsecure_attr_nxt       = wr_data[A_NS_BIT];
      sec_incorrect_nxt        = wr_data[A_SI_BIT];
      address_incorrect_nxt    = wr_data[A_AI_BIT];
      virtual_address_flag_nxt = VA_IMPL && wr_data[A_VA_BIT];
      space_extension_bit_nxt  = RME_IMPL && wr_data[A_NSE_BIT];
      paddr_nxt                = wr_data[A_PA_MSB:0] & PA_MASK;
    end
  end

  // Cold reset gives zero; no other reset touches these fields
  always_ff @(posedge clk) begin
    if (srst) begin
      nonsecure_attr_r       <= 1'b0;
      space_extension_bit_r  <= 1'b0;
      sec_incorrect_r        <= 1'b0;
      address_incorrect_r    <= 1'b0;
      virtual_address_flag_r <= 1'b0;
      paddr_r                <= '0;
    end else begin
      nonsecure_attr_r       <= nonsecure_attr_nxt;
      space_extension_bit_r  <= space_extension_bit_nxt;
      sec_incorrect_r        <= sec_incorrect_nxt;
      address_incorrect_r    <= address_incorrect_nxt;
      virtual_address_flag_r <= virtual_address_flag_nxt;
      paddr_r                <= paddr_nxt;
    end
  end

  assign rd_data = {nonsecure_attr_r, sec_incorrect_r, address_incorrect_r,
                    virtual_address_flag_r, space_extension_bit_r, 3'h0, paddr_r};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_va_capture;
    @(posedge clk) disable iff (srst)
    cap_en && cap_va |=> rd_data[63:59] == {2'h1, 1'h1, VA_IMPL, 1'h0};
  endproperty
  a_va_capture: assert property (p_va_capture)
    else $error("Virtual capture did not force flags");

  property p_locked_write;
    @(posedge clk) disable iff (srst)
    wr_en && wr_lock && !cap_en |=> $stable(rd_data);
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("Write accepted while record valid");

  property p_capture_addr;
    @(posedge clk) disable iff (srst)
    cap_en |=> rd_data[A_PA_MSB:0] == ($past(cap_addr) & PA_MASK);
  endproperty
  a_capture_addr: assert property (p_capture_addr)
    else $error("Captured address not stored");

endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the error record address and control block.
// Assumes erac_top with default parameters on one 250 MHz clock.
module tb_top
  import erac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and expected state
  // ----------------------------------------------------------------
  localparam logic [63:0] AMASK = 64'hf800_ffff_ffff_ffff;
  localparam logic [63:0] CMASK = 64'h0000_0000_0000_2f00;
  logic        CORE_CLK = 1'b0, SRST = 1'b1, ERR_RECOVERY_RST = 1'b0;
  logic [1:0]  SR_SEL = 2'h0, CAP_REC = 2'h0;
  erac_sreg_t  SR_REG = ERAC_SREG_CTL;
  logic        SR_WR = 1'b0, SR_RD = 1'b0, MM_WR = 1'b0, MM_RD = 1'b0;
  logic [63:0] SR_WDATA = 64'h0, MM_WDATA = 64'h0, SR_RDATA, MM_RDATA;
  logic [7:0]  MM_ADDR = 8'h0;
  logic        CAP_VALID = 1'b0, CAP_NS = 1'b0, CAP_NSE = 1'b0;
  logic        CAP_SI = 1'b0, CAP_AI = 1'b0, CAP_VA = 1'b0;
  logic [55:0] CAP_ADDR = 56'h0;
  logic [3:0]  STATUS_AV = 4'h0;
  logic        EV_CRIT = 1'b0, EV_DEFERRED = 1'b0, EV_CORRECTED = 1'b0, EV_WRITE = 1'b0;
  logic        CRIT_IRQ, CRIT_AS_UNCONTAINED, RECOVERY_IRQ, FAULT_IRQ;
  logic        CE_OVF_SET = 1'b0;
  logic [3:0]  irq_seen;
  logic [63:0] rd, v, cexp;
  logic [63:0] aexp [4];
  logic [1:0]  rec;
  int          n_fail = 0, checks = 0, seed_v;

  always #2 CORE_CLK = ~CORE_CLK;

  assign irq_seen = {CRIT_IRQ, CRIT_AS_UNCONTAINED, RECOVERY_IRQ, FAULT_IRQ};

  erac_top i_erac_top (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .ERR_RECOVERY_RST(ERR_RECOVERY_RST),
    .SR_SEL(SR_SEL), .SR_REG(SR_REG), .SR_WR(SR_WR), .SR_RD(SR_RD),
    .SR_WDATA(SR_WDATA), .SR_RDATA(SR_RDATA), .MM_ADDR(MM_ADDR), .MM_WR(MM_WR),
    .MM_RD(MM_RD), .MM_WDATA(MM_WDATA), .MM_RDATA(MM_RDATA), .CAP_VALID(CAP_VALID),
    .CAP_REC(CAP_REC), .CAP_ADDR(CAP_ADDR), .CAP_NS(CAP_NS), .CAP_NSE(CAP_NSE),
    .CAP_SI(CAP_SI), .CAP_AI(CAP_AI), .CAP_VA(CAP_VA), .STATUS_AV(STATUS_AV),
    .EV_CRIT(EV_CRIT), .EV_DEFERRED(EV_DEFERRED), .EV_CORRECTED(EV_CORRECTED),
    .EV_WRITE(EV_WRITE), .CE_OVF_SET(CE_OVF_SET), .CRIT_IRQ(CRIT_IRQ),
    .CRIT_AS_UNCONTAINED(CRIT_AS_UNCONTAINED), .RECOVERY_IRQ(RECOVERY_IRQ),
    .FAULT_IRQ(FAULT_IRQ)
  );

  // ----------------------------------------------------------------
  // Compare, access and expectation helpers
  // ----------------------------------------------------------------
  task automatic chk64(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk4(input string nm, input logic [3:0] exp, input logic [3:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic acc(input bit mm, input bit wr, input logic [1:0] r, input erac_sreg_t rg,
                     input logic [63:0] wd, output logic [63:0] q);
    @(negedge CORE_CLK);
    if (mm) begin
      MM_ADDR = {r, (rg == ERAC_SREG_CTL) ? CTL_OFF : ADDR_OFF};
      MM_WDATA = wd;
      MM_WR = wr;
      MM_RD = !wr;
    end else begin
      SR_SEL = r;
      SR_REG = rg;
      SR_WDATA = wd;
      SR_WR = wr;
      SR_RD = !wr;
    end
    @(negedge CORE_CLK);
    {MM_WR, MM_RD, SR_WR, SR_RD} = 4'h0;
    q = mm ? MM_RDATA : SR_RDATA;
  endtask

  function automatic logic [3:0] irq_exp(logic [63:0] c, logic [3:0] e);
    irq_exp = {e[3] & c[13], e[3] & !c[13], e[2] & (e[0] ? c[11] : c[10]),
               e[1] & (e[0] ? c[9] : c[8])};
  endfunction

  task automatic ev(input logic [3:0] e);
    logic [3:0] x;
    @(negedge CORE_CLK);
    {EV_CRIT, EV_DEFERRED, EV_CORRECTED, EV_WRITE} = e;
    ERR_RECOVERY_RST = e[0] ^ e[2];
    CE_OVF_SET = ~e[1];
    x = irq_exp(cexp, e);
    @(negedge CORE_CLK);
    {EV_CRIT, EV_DEFERRED, EV_CORRECTED, EV_WRITE} = 4'h0;
    ERR_RECOVERY_RST = 1'b0;
    CE_OVF_SET = 1'b0;
    chk4("irq", x, irq_seen);
    @(negedge CORE_CLK);
    chk4("irq_end", 4'h0, irq_seen);
  endtask

  task automatic stop_test;
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    n_fail++;
    stop_test;
  end

  initial begin
    seed_v = $urandom(44);
    repeat (4) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    SRST = 1'b0;
    for (int r = 0; r < 4; r++) begin
      acc(r[0], 1'b0, r[1:0], ERAC_SREG_CTL, 64'h0, rd);
      chk64("ctl_cold", 64'h0, rd);
      acc(!r[0], 1'b0, r[1:0], ERAC_SREG_ADDR, 64'h0, rd);
      chk64("addr_cold", 64'h0, rd);
      aexp[r] = 64'h0;
    end
    cexp = 64'h0;
    for (int i = 0; i < 12; i++) begin
      v = (i == 0) ? 64'hffff_ffff_ffff_ffff : {$urandom, $urandom};
      acc(i[0], 1'b1, 2'h0, ERAC_SREG_CTL, v, rd);
      cexp = v & CMASK;
      acc(!i[0], 1'b0, 2'h0, ERAC_SREG_CTL, 64'h0, rd);
      chk64("ctl_cross", cexp, rd);
      rec = 2'(1 + i % 3);
      acc(i[0], 1'b1, rec, ERAC_SREG_CTL, v, rd);
      acc(i[1], 1'b0, rec, ERAC_SREG_CTL, 64'h0, rd);
      chk64("ctl_other", 64'h0, rd);
    end
    for (int i = 0; i < 16; i++) begin
      rec = 2'($urandom);
      v = (i == 0) ? 64'hffff_ffff_ffff_ffff : {$urandom, $urandom};
      STATUS_AV = 4'($urandom);
      acc(i[0], 1'b1, rec, ERAC_SREG_ADDR, v, rd);
      if (STATUS_AV[rec] === 1'b0) aexp[rec] = v & AMASK;
      acc(!i[0], 1'b0, rec, ERAC_SREG_ADDR, 64'h0, rd);
      chk64("addr_sw", aexp[rec], rd);
    end
    STATUS_AV = 4'h0;
    for (int i = 0; i < 16; i++) begin
      @(negedge CORE_CLK);
      CAP_REC = 2'($urandom);
      {CAP_NS, CAP_NSE, CAP_SI, CAP_AI, CAP_VA} = 5'($urandom) | ((i < 3) ? 5'h01 : 5'h00);
      CAP_ADDR = {24'($urandom), 32'($urandom)};
      CAP_VALID = 1'b1;
      @(negedge CORE_CLK);
      CAP_VALID = 1'b0;
      aexp[CAP_REC] = AMASK & (CAP_VA ? {5'h0e, 3'h0, CAP_ADDR}
                    : {CAP_NS, CAP_SI, CAP_AI, 1'b0, CAP_NSE, 3'h0, CAP_ADDR});
      acc(i[0], 1'b0, CAP_REC, ERAC_SREG_ADDR, 64'h0, rd);
      chk64("addr_cap", aexp[CAP_REC], rd);
    end
    @(negedge CORE_CLK);
    ERR_RECOVERY_RST = 1'b1;
    repeat (3) @(negedge CORE_CLK);
    ERR_RECOVERY_RST = 1'b0;
    for (int r = 0; r < 4; r++) begin
      acc(r[1], 1'b0, r[1:0], ERAC_SREG_ADDR, 64'h0, rd);
      chk64("addr_keep", aexp[r], rd);
    end
    acc(1'b0, 1'b0, 2'h0, ERAC_SREG_CTL, 64'h0, rd);
    chk64("ctl_keep", cexp, rd);
    for (int i = 0; i < 24; i++) begin
      v = (i < 2) ? {64{i[0]}} : {$urandom, $urandom};
      acc(i[0], 1'b1, 2'h0, ERAC_SREG_CTL, v, rd);
      cexp = v & CMASK;
      for (int k = 0; k < 4; k++) ev((i < 2) ? 4'(8 + 4 * (k / 2) + k % 2) : 4'($urandom));
    end
    stop_test;
  end
endmodule
